// File: src/svf_regs.svh
`ifndef SVF_REGS_SVH
`define SVF_REGS_SVH
// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SVF_SAMPLE_W 8
`define SVF_TIME_W 32
`define SVF_CNT_W 16
`define SVF_FIFO_DEPTH 8
`define SVF_MARK_DEPTH 64
`define SVF_MARK_AW 6
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SVF_CLK_HZ 100000000
`define SVF_X1_PPS 30000
`define SVF_MAX_SPEED 4
// Least legal spacing of sample pulses at the fastest playback.
`define SVF_MIN_TICK_CYC ((`SVF_CLK_HZ) / (`SVF_X1_PPS * `SVF_MAX_SPEED))
`define SVF_TICK_CNT_W 12
`endif

// File: src/svf_pkg.sv
`default_nettype none
package svf_pkg;
   typedef logic [7:0] svf_sample_t;
   typedef logic [31:0] svf_time_t;
   typedef logic [15:0] svf_cnt_t;
   typedef enum logic [1:0] {
      SVF_IDLE,
      SVF_HIGH
   } svf_edge_t;
endpackage : svf_pkg
`default_nettype wire

// File: src/svf_if.sv
`timescale 1ns/1ns
`default_nettype none
interface svf_link_if (
   input wire logic clk
);
   svf_pkg::svf_sample_t sample_data;
   logic sample_valid;
   logic sample_ready;
   logic frame_irq;
   logic line_irq;
   logic marker_irq;
   svf_pkg::svf_time_t time_word;

   modport dev (
      input clk,
      output sample_data,
      output sample_valid,
      input sample_ready,
      output frame_irq,
      output line_irq,
      output marker_irq,
      output time_word
   );
   modport host (
      input clk,
      input sample_data,
      input sample_valid,
      output sample_ready,
      input frame_irq,
      input line_irq,
      input marker_irq,
      input time_word
   );
endinterface : svf_link_if
`default_nettype wire

// File: src/svf_formatter.sv
// What this block does
// [RL1] One 8-bit sample per sample clock pulse.
// [RL2] Sample pulses track tape speed, 5 km steps.
// [RL3] Single speed gives 30,000 samples per second.
// [RL4] Frame sync interrupts; line number cleared.
// [RL5] Line sync interrupts; range number cleared.
// [RL6] Each frequency marker raises an interrupt.
// [RL7] Computer stores time word on marker interrupt; the code stores only the first 64 markers.
// [RL8] Path sustains four times speed playback.
// [RL9] Time word is tape time, millisecond units.
// [RL10] Range counts samples; line counts line syncs.
`include "svf_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------
module svf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : svf_fifo

// ----------------------------------------------------------------
// Formatter end
// ----------------------------------------------------------------
module svf_formatter (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sample_tick,
   input wire logic [`SVF_SAMPLE_W-1:0] adc_code,
   input wire logic frame_sync,
   input wire logic line_sync,
   input wire logic marker_pulse,
   input wire logic [`SVF_TIME_W-1:0] tape_time_ms,
   output logic sample_lost_reg,
   output logic rate_error_reg,
   svf_link_if.dev link
);
   logic [3:0] pulse_d_reg;
   logic [3:0] pulse_rise;
   logic [`SVF_TICK_CNT_W-1:0] gap_reg;
   logic out_valid_reg;
   svf_pkg::svf_sample_t out_data_reg;
   logic frame_irq_reg;
   logic line_irq_reg;
   logic marker_irq_reg;
   svf_pkg::svf_time_t time_word_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   svf_pkg::svf_sample_t fifo_out_data;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // Pulses are taken on their rising edge so a wide pulse counts once.
   // The delay bits reset low, the idle level of every pulse input, so
   // no false edge follows reset.
   function automatic logic rose_now(
      input logic now_level,
      input logic last_level
   );
      return now_level && !last_level;
   endfunction : rose_now

   wire [3:0] pulse_in = {marker_pulse, line_sync, frame_sync, sample_tick};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         assign pulse_rise[gi] = rose_now(pulse_in[gi], pulse_d_reg[gi]);
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               pulse_d_reg[gi] <= 1'b0;
            end else begin
               pulse_d_reg[gi] <= pulse_in[gi];
            end
         end
      end
   endgenerate

   wire tick_rise = pulse_rise[0];
   wire frame_rise = pulse_rise[1];
   wire line_rise = pulse_rise[2];
   wire marker_rise = pulse_rise[3];

   // ----------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------
   wire out_free = !out_valid_reg || link.sample_ready;
   wire fifo_pop = fifo_out_valid && out_free;
   wire tick_too_soon = tick_rise &&
      (gap_reg < `SVF_TICK_CNT_W'(`SVF_MIN_TICK_CYC));

   svf_fifo #(
      .WIDTH(`SVF_SAMPLE_W),
      .DEPTH(`SVF_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(adc_code),
      .in_valid(tick_rise), // [RL1]
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(out_free) // [RL8]
   );

   // ----------------------------------------------------------------
   // Link outputs
   // ----------------------------------------------------------------
   assign link.sample_data = out_data_reg;
   assign link.sample_valid = out_valid_reg;
   assign link.frame_irq = frame_irq_reg;
   assign link.line_irq = line_irq_reg;
   assign link.marker_irq = marker_irq_reg;
   assign link.time_word = time_word_reg;

   // ----------------------------------------------------------------
   // Rate watch
   // ----------------------------------------------------------------
   // Spacing watch: pulses closer than the fastest playback allows are
   // flagged, since the link is only sized for that rate.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gap_reg <= '1;
         rate_error_reg <= 1'b0;
      end else begin
         if (tick_rise) begin
            gap_reg <= '0;
         end else if (gap_reg != '1) begin
            gap_reg <= gap_reg + 1'b1;
         end
         if (tick_too_soon) rate_error_reg <= 1'b1; // [RL2] [RL3] [RL8]
      end
   end

   // ----------------------------------------------------------------
   // Output register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
         sample_lost_reg <= 1'b0;
      end else begin
         if (out_free) out_valid_reg <= fifo_out_valid;
         if (fifo_pop) out_data_reg <= fifo_out_data;
         // A sample that meets a full FIFO is dropped and remembered.
         if (tick_rise && !fifo_in_ready) sample_lost_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         frame_irq_reg <= 1'b0;
         line_irq_reg <= 1'b0;
         marker_irq_reg <= 1'b0;
         time_word_reg <= '0;
      end else begin
         frame_irq_reg <= frame_rise; // [RL4]
         line_irq_reg <= line_rise; // [RL5]
         marker_irq_reg <= marker_rise; // [RL6]
         if (marker_rise) time_word_reg <= tape_time_ms; // [RL9]
      end
   end
endmodule : svf_formatter
`default_nettype wire

// File: src/svf_computer.sv
`include "svf_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Computer end
// ----------------------------------------------------------------
module svf_computer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic user_ready,
   input wire logic [`SVF_MARK_AW-1:0] mark_idx,
   output logic word_valid_reg,
   output logic [`SVF_SAMPLE_W-1:0] word_data_reg,
   output logic [`SVF_CNT_W-1:0] word_range_reg,
   output logic [`SVF_CNT_W-1:0] word_line_reg,
   output logic [`SVF_MARK_AW:0] mark_count_reg,
   output logic [`SVF_TIME_W-1:0] mark_time_reg,
   svf_link_if.host link
);
   logic ready_reg;
   svf_pkg::svf_cnt_t range_reg;
   svf_pkg::svf_cnt_t line_reg;
   svf_pkg::svf_time_t mark_mem [`SVF_MARK_DEPTH];

   wire take = link.sample_valid && ready_reg;
   // A line sync in the same cycle as a sample makes that sample index 0.
   wire [`SVF_CNT_W-1:0] range_now = link.line_irq ? '0 : range_reg;
   wire mark_room = (mark_count_reg != (`SVF_MARK_AW+1)'(`SVF_MARK_DEPTH));
   // Entries not yet written read as zero through the mark_known gate, as the store is not reset.
   wire mark_known = ({1'b0, mark_idx} < mark_count_reg);

   assign link.sample_ready = ready_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ready_reg <= 1'b0;
         word_valid_reg <= 1'b0;
         word_data_reg <= '0;
         word_range_reg <= '0;
         word_line_reg <= '0;
      end else begin
         ready_reg <= user_ready; // [RL8]
         word_valid_reg <= take;
         if (take) begin
            word_data_reg <= link.sample_data;
            word_range_reg <= range_now;
            word_line_reg <= line_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         range_reg <= '0;
         line_reg <= '0;
      end else begin
         range_reg <= range_now + svf_pkg::svf_cnt_t'(take); // [RL5] [RL10]
         if (link.frame_irq) begin
            line_reg <= '0; // [RL4]
         end else if (link.line_irq) begin
            line_reg <= line_reg + 1'b1; // [RL10]
         end
      end
   end

   // Marker times are kept until reset; later markers beyond the store
   // are not recorded.
   always_ff @(posedge clk) begin
      if (link.marker_irq && mark_room) begin
         mark_mem[mark_count_reg[`SVF_MARK_AW-1:0]] <= link.time_word; // [RL7]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mark_count_reg <= '0;
         mark_time_reg <= '0;
      end else begin
         if (link.marker_irq && mark_room) begin
            mark_count_reg <= mark_count_reg + 1'b1; // [RL7]
         end
         mark_time_reg <= mark_known ? mark_mem[mark_idx] : '0;
      end
   end
endmodule : svf_computer
`default_nettype wire

// File: dv/svf_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Link checker
// ------------------------------------------------
module svf_link_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire svf_pkg::svf_sample_t sample_data,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic frame_irq,
   input wire logic line_irq,
   input wire logic marker_irq,
   input wire svf_pkg::svf_time_t time_word
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_valid_holds:
      assert property (sample_valid && !sample_ready |=> sample_valid)
      else $error("sample withdrawn while stalled");
   a_data_stable:
      assert property (sample_valid && !sample_ready |=> $stable(sample_data))
      else $error("sample code changed while stalled");
   a_frame_pulse:
      assert property (frame_irq |=> !frame_irq)
      else $error("frame interrupt longer than one cycle");
   a_line_pulse:
      assert property (line_irq |=> !line_irq)
      else $error("line interrupt longer than one cycle");
   a_marker_pulse:
      assert property (marker_irq |=> !marker_irq)
      else $error("marker interrupt longer than one cycle");
   a_time_at_marker:
      assert property ($changed(time_word) |-> marker_irq)
      else $error("time word moved without a marker");
   a_stall_two_held:
      assert property ((sample_valid && !sample_ready) [*2] |=>
         sample_data == $past(sample_data, 2))
      else $error("sample code lost across a stall");
   a_idle_after_reset:
      assert property ($rose(reset_n) |->
         !(sample_valid | frame_irq | line_irq | marker_irq) ##1 !sample_valid)
      else $error("link busy straight after reset");
   c_handshake: cover property (sample_valid && sample_ready);
   c_stall: cover property (sample_valid && !sample_ready);
   c_marker: cover property (marker_irq);
endmodule : svf_link_assertions
`default_nettype wire

// File: dv/sounder_video_sample_formatter_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Bench
// ------------------------------------------------
module sounder_video_sample_formatter_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic tick = 1'b0;
   logic [7:0] adc = 8'h00;
   logic frame_s = 1'b0;
   logic line_s = 1'b0;
   logic mark_s = 1'b0;
   logic [31:0] tape_t = 32'h0000_0000;
   logic rdy = 1'b0;
   logic [5:0] idx = 6'h00;
   logic lost, rate_err, wv;
   logic [7:0] wd;
   logic [15:0] wr, wl;
   logic [6:0] mc;
   logic [31:0] mt;
   logic [39:0] q[$];
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   svf_link_if u_svf_link_if (.clk(clk));
   svf_formatter u_svf_formatter (.clk(clk), .reset_n(reset_n),
      .sample_tick(tick), .adc_code(adc), .frame_sync(frame_s),
      .line_sync(line_s), .marker_pulse(mark_s), .tape_time_ms(tape_t),
      .sample_lost_reg(lost), .rate_error_reg(rate_err),
      .link(u_svf_link_if.dev));
   svf_computer u_svf_computer (.clk(clk), .reset_n(reset_n),
      .user_ready(rdy), .mark_idx(idx), .word_valid_reg(wv),
      .word_data_reg(wd), .word_range_reg(wr), .word_line_reg(wl),
      .mark_count_reg(mc), .mark_time_reg(mt), .link(u_svf_link_if.host));
   svf_link_assertions u_svf_link_assertions (.clk(clk), .reset_n(reset_n),
      .sample_data(u_svf_link_if.sample_data),
      .sample_valid(u_svf_link_if.sample_valid),
      .sample_ready(u_svf_link_if.sample_ready),
      .frame_irq(u_svf_link_if.frame_irq), .line_irq(u_svf_link_if.line_irq),
      .marker_irq(u_svf_link_if.marker_irq),
      .time_word(u_svf_link_if.time_word));
   always #5 clk = ~clk;
   // Words are one-cycle pulses, so they are queued as they come.
   always @(negedge clk) begin
      cycles++;
      if (wv === 1'b1) begin
         q.push_back({wl, wr, wd});
      end
      if (cycles == 30000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : check
   // Spacing of 840 keeps clear of the 833-cycle rate limit.
   task automatic send(input logic [7:0] c);
      adc = c;
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      repeat (840) @(negedge clk);
   endtask : send
   task automatic sync(input logic [2:0] s);
      {frame_s, line_s, mark_s} = s;
      @(negedge clk);
      {frame_s, line_s, mark_s} = 3'b000;
      repeat (4) @(negedge clk);
   endtask : sync
   task automatic take(input logic [39:0] exp);
      check(40'(q.size() != 0), 40'h1);
      if (q.size() != 0) begin
         check(q.pop_front(), exp);
      end
   endtask : take
   task automatic test_stream();
      rdy = 1'b1;
      sync(3'b100);
      sync(3'b010);
      send(8'h11);
      take({16'h1, 16'h0, 8'h11});
      send(8'hee);
      take({16'h1, 16'h1, 8'hee});
      sync(3'b010);
      send(8'h00);
      take({16'h2, 16'h0, 8'h00});
      sync(3'b100);
      send(8'hff);
      take({16'h0, 16'h1, 8'hff});
      check(40'(rate_err), 40'h0);
   endtask : test_stream
   task automatic test_marker();
      tape_t = 32'h0001_2345;
      sync(3'b001);
      tape_t = 32'hffff_fffe;
      sync(3'b001);
      check(40'(mc), 40'h2);
      check(40'(u_svf_link_if.time_word), 40'hffff_fffe);
      idx = 6'h00;
      repeat (2) @(negedge clk);
      check(40'(mt), 40'h0001_2345);
      idx = 6'h01;
      repeat (2) @(negedge clk);
      check(40'(mt), 40'hffff_fffe);
      for (int i = 0; i < 63; i++) begin
         sync(3'b001);
      end
      check(40'(mc), 40'h40);
   endtask : test_marker
   task automatic test_fill();
      rdy = 1'b0;
      for (int i = 0; i < 10; i++) begin
         send(8'(i));
         check(40'(lost), 40'(i == 9));
      end
      rdy = 1'b1;
      repeat (20) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
         take({16'h0, 16'(i + 2), 8'(i)});
      end
      check(40'(q.size()), 40'h0);
   endtask : test_fill
   task automatic test_rate();
      check(40'(rate_err), 40'h0);
      adc = 8'h5a;
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      repeat (10) @(negedge clk);
      send(8'ha5);
      check(40'(rate_err), 40'h1);
      take({16'h0, 16'h000b, 8'h5a});
      take({16'h0, 16'h000c, 8'ha5});
   endtask : test_rate
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      test_stream();
      test_marker();
      test_fill();
      test_rate();
      test_done();
   end
endmodule : sounder_video_sample_formatter_tb
`default_nettype wire
